// ---- verilog/aesd_decryptor.sv ----
`timescale 1ns/100ps

// Summary of operation
// - one clock sys_clk; low nrst forces control state back to idle.
// - key strobe taken in idle starts key setup lasting 14 cycles.
// - key_setup_busy high from cycle after acceptance through last setup cycle.
// - during key setup both strobes are ignored; nothing new starts.
// - key_setup_done pulses in the last key setup cycle.
// - stored round keys serve every decryption until a new key loads or low nrst clears them.
// - decrypt_busy_flag rises next cycle and stays high 14 cycles.
// - during decryption both strobes are ignored.
// - decrypt_done_flag pulses in the last decryption cycle.
// - finished plaintext drives plain_result_word with plain_result_strobe high.
// - datapath is the standard inverse cipher with a 256-bit key.
module aesd_decryptor
   import aesd_pkg::*;
(
   input wire logic sys_clk, // system clock
   input wire logic nrst, // asynchronous reset, low active
   input wire logic key_load_strobe, // key_word valid, starts key setup
   input wire logic [KEY_W-1:0] key_word, // cipher key, first byte in top bits
   output logic key_setup_busy, // key setup running
   output logic key_setup_done, // last key setup cycle
   input wire logic block_in_strobe, // block_in_word valid, starts decryption
   input wire logic [BLK_W-1:0] block_in_word, // ciphertext block
   output logic decrypt_busy_flag, // decryption running
   output logic decrypt_done_flag, // last decryption cycle
   output logic plain_result_strobe, // plain_result_word fresh this cycle
   output logic [BLK_W-1:0] plain_result_word // plaintext, held until next result
);

   // forward S-box on each byte of one word of the 256-bit schedule
   function automatic logic [WORD_W-1:0] sub_word(input logic [WORD_W-1:0] w);
      return {aesd_sbox(w[31:24]), aesd_sbox(w[23:16]), aesd_sbox(w[15:8]), aesd_sbox(w[7:0])};
   endfunction

   // step a phase counter by one
   function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] c);
      return c + FIRST_CYCLE;
   endfunction

   // byte rotation of one schedule word
   function automatic logic [WORD_W-1:0] rot_word(input logic [WORD_W-1:0] w);
      return {w[23:0], w[31:24]};
   endfunction

   // round constant for an even schedule index
   function automatic logic [7:0] round_const(input logic [CNT_W-1:0] idx);
      logic [2:0] step;
      step = idx[CNT_W-1:1] - FIRST_CYCLE[2:0];
      return RCON_FIRST << step;
   endfunction

   // chain the four words of a new round key from the older key
   function automatic logic [BLK_W-1:0] chain_words(input logic [BLK_W-1:0] older, input logic [WORD_W-1:0] mix);
      logic [BLK_W-1:0] k;
      k[127:96] = older[127:96] ^ mix;
      k[95:64] = older[95:64] ^ k[127:96];
      k[63:32] = older[63:32] ^ k[95:64];
      k[31:0] = older[31:0] ^ k[63:32];
      return k;
   endfunction

   aesd_state_e state;
   aesd_state_e next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [BLK_W-1:0] round_keys [0:ROUNDS];
   logic [BLK_W-1:0] next_round_keys [0:ROUNDS];
   logic [BLK_W-1:0] work;
   logic [BLK_W-1:0] next_work;
   logic [BLK_W-1:0] next_plain_word;
   logic next_plain_strobe;

   // key schedule helper signals
   logic [BLK_W-1:0] key_older;
   logic [BLK_W-1:0] key_newer;
   logic [BLK_W-1:0] key_gen;
   logic [WORD_W-1:0] key_mix;
   logic [7:0] rcon;
   logic [CNT_W-1:0] gen_index;
   logic [CNT_W-1:0] rk_index;

   aesd_round_if rnd_bus ();

   aesd_inv_round u_round (
      .rnd(rnd_bus.datapath)
   );

   // status flags decoded from the control state
   always_comb begin
      key_setup_busy = (state == ST_KEY);
      key_setup_done = (state == ST_KEY) && (cnt == KEY_SETUP_CYCLES);
      decrypt_busy_flag = (state == ST_DEC);
      decrypt_done_flag = (state == ST_DEC) && (cnt == DEC_CYCLES);
   end

   // next round key from the two before it
   always_comb begin
      gen_index = count_up(cnt);
      key_older = round_keys[cnt - FIRST_CYCLE];
      key_newer = round_keys[cnt];
      rcon = round_const(gen_index);
      if (gen_index[0] == 1'b0) begin
         key_mix = sub_word(rot_word(key_newer[31:0])) ^ {rcon, 24'h000000};
      end else begin
         key_mix = sub_word(key_newer[31:0]);
      end
      key_gen = chain_words(key_older, key_mix);
   end

   // round key walked downwards, final round skips the column mix
   always_comb begin
      rk_index = LAST_ROUND_INDEX - cnt;
      rnd_bus.state_in = work;
      rnd_bus.round_key = round_keys[rk_index];
      rnd_bus.final_round = (cnt == DEC_CYCLES);
   end

   // control sequencing, key storage and block datapath
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_round_keys = round_keys;
      next_work = work;
      next_plain_word = plain_result_word;
      next_plain_strobe = 1'b0;
      case (state)
         ST_IDLE: begin
            // strobes only count here, so busy phases ignore them; key wins
            if (key_load_strobe) begin
               next_round_keys[0] = key_word[KEY_W-1:BLK_W];
               next_round_keys[1] = key_word[BLK_W-1:0];
               next_cnt = FIRST_CYCLE;
               next_state = ST_KEY;
            end else if (block_in_strobe) begin
               next_work = block_in_word ^ round_keys[ROUNDS];
               next_cnt = FIRST_CYCLE;
               next_state = ST_DEC;
            end
         end
         ST_KEY: begin
            // no strobe is looked at in this state
            if (cnt <= LAST_KEY_GEN_CYCLE) begin
               next_round_keys[gen_index] = key_gen;
            end
            if (cnt == KEY_SETUP_CYCLES) begin
               next_state = ST_IDLE;
               next_cnt = '0;
            end else begin
               next_cnt = count_up(cnt);
            end
         end
         ST_DEC: begin
            // no strobe is looked at in this state
            next_work = rnd_bus.state_out;
            if (cnt == DEC_CYCLES) begin
               next_plain_word = rnd_bus.state_out;
               next_plain_strobe = 1'b1;
               next_state = ST_IDLE;
               next_cnt = '0;
            end else begin
               next_cnt = count_up(cnt);
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_cnt = '0;
         end
      endcase
   end

   // state registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         cnt <= '0;
         work <= BLK_RESET;
         plain_result_word <= BLK_RESET;
         plain_result_strobe <= 1'b0;
         for (int i = 0; i <= ROUNDS; i++) begin
            round_keys[i] <= BLK_RESET;
         end
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         work <= next_work;
         plain_result_word <= next_plain_word;
         plain_result_strobe <= next_plain_strobe;
         round_keys <= next_round_keys;
      end
   end

endmodule

// ---- include/aesd_pkg.sv ----
package aesd_pkg;

   // datapath widths
   localparam int KEY_W = 256;
   localparam int BLK_W = 128;
   localparam int WORD_W = 32;
   localparam int CNT_W = 4;

   // cycle counts of both operations
   localparam int ROUNDS = 14;
   localparam logic [CNT_W-1:0] KEY_SETUP_CYCLES = 4'hE;
   localparam logic [CNT_W-1:0] DEC_CYCLES = 4'hE;
   localparam logic [CNT_W-1:0] FIRST_CYCLE = 4'h1;
   localparam logic [CNT_W-1:0] LAST_KEY_GEN_CYCLE = 4'hD;
   localparam logic [CNT_W-1:0] LAST_ROUND_INDEX = 4'hE;

   // field constants of the cipher
   localparam logic [7:0] GF_POLY = 8'h1B;
   localparam logic [7:0] SBOX_AFFINE = 8'h63;
   localparam logic [7:0] INV_AFFINE = 8'h05;
   localparam logic [7:0] RCON_FIRST = 8'h01;
   localparam logic [BLK_W-1:0] BLK_RESET = 128'h0;

   // control states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_KEY = 3'b010,
      ST_DEC = 3'b100
   } aesd_state_e;

   // multiply in gf(2^8) modulo the field polynomial
   function automatic logic [7:0] aesd_gf_mul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h00;
      x = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) begin
            p = p ^ x;
         end
         x = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY : 8'h00);
      end
      return p;
   endfunction

   // inverse as a^254; zero maps to zero; logic traded for table storage
   function automatic logic [7:0] aesd_gf_inv(input logic [7:0] a);
      logic [7:0] p;
      logic [7:0] r;
      p = a;
      r = 8'h01;
      for (int i = 1; i < 8; i++) begin
         p = aesd_gf_mul(p, p);
         r = aesd_gf_mul(r, p);
      end
      return r;
   endfunction

   // forward substitution, used by the key schedule
   function automatic logic [7:0] aesd_sbox(input logic [7:0] a);
      logic [7:0] x;
      x = aesd_gf_inv(a);
      return x ^ {x[6:0], x[7]} ^ {x[5:0], x[7:6]} ^ {x[4:0], x[7:5]} ^ {x[3:0], x[7:4]} ^ SBOX_AFFINE;
   endfunction

   // inverse substitution, used by the rounds
   function automatic logic [7:0] aesd_inv_sbox(input logic [7:0] a);
      logic [7:0] y;
      y = {a[6:0], a[7]} ^ {a[4:0], a[7:5]} ^ {a[1:0], a[7:2]} ^ INV_AFFINE;
      return aesd_gf_inv(y);
   endfunction

endpackage

// ---- include/aesd_round_if.sv ----
`timescale 1ns/100ps

// carries one inverse round between control and datapath
interface aesd_round_if;
   import aesd_pkg::*;
   logic [BLK_W-1:0] state_in;
   logic [BLK_W-1:0] round_key;
   logic final_round;
   logic [BLK_W-1:0] state_out;

   modport datapath (input state_in, input round_key, input final_round, output state_out);
   modport control (output state_in, output round_key, output final_round, input state_out);
endinterface

// ---- verilog/aesd_inv_round.sv ----
`timescale 1ns/100ps

module aesd_inv_round
   import aesd_pkg::*;
(
   aesd_round_if.datapath rnd // one round, combinational
);

   // inverse column mix of one 32-bit column
   function automatic logic [31:0] inv_mix_col(input logic [31:0] c);
      logic [7:0] a0;
      logic [7:0] a1;
      logic [7:0] a2;
      logic [7:0] a3;
      a0 = c[31:24];
      a1 = c[23:16];
      a2 = c[15:8];
      a3 = c[7:0];
      return {aesd_gf_mul(a0, 8'h0E) ^ aesd_gf_mul(a1, 8'h0B) ^ aesd_gf_mul(a2, 8'h0D) ^ aesd_gf_mul(a3, 8'h09),
              aesd_gf_mul(a0, 8'h09) ^ aesd_gf_mul(a1, 8'h0E) ^ aesd_gf_mul(a2, 8'h0B) ^ aesd_gf_mul(a3, 8'h0D),
              aesd_gf_mul(a0, 8'h0D) ^ aesd_gf_mul(a1, 8'h09) ^ aesd_gf_mul(a2, 8'h0E) ^ aesd_gf_mul(a3, 8'h0B),
              aesd_gf_mul(a0, 8'h0B) ^ aesd_gf_mul(a1, 8'h0D) ^ aesd_gf_mul(a2, 8'h09) ^ aesd_gf_mul(a3, 8'h0E)};
   endfunction

   logic [BLK_W-1:0] shifted;
   logic [BLK_W-1:0] keyed;

   // inverse row shift and substitution, then round key and column mix
   always_comb begin
      shifted = BLK_RESET;
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            shifted[BLK_W-1-8*(r+4*c) -: 8] = aesd_inv_sbox(rnd.state_in[BLK_W-1-8*(r+4*((c-r+4)%4)) -: 8]);
         end
      end
      keyed = shifted ^ rnd.round_key;
      rnd.state_out = keyed;
      if (!rnd.final_round) begin
         for (int c = 0; c < 4; c++) begin
            rnd.state_out[BLK_W-1-32*c -: 32] = inv_mix_col(keyed[BLK_W-1-32*c -: 32]);
         end
      end
   end

endmodule

// ---- verification/aesd_decryptor_sva.sv ----
`timescale 1ns/100ps

module aesd_decryptor_chk
   import aesd_pkg::*;
(
   input wire logic sys_clk, // clock
   input wire logic nrst, // reset, low active
   input wire logic key_load_strobe, // key request
   input wire logic [KEY_W-1:0] key_word, // key value
   input wire logic key_setup_busy, // key setup running
   input wire logic key_setup_done, // last setup cycle
   input wire logic block_in_strobe, // block request
   input wire logic [BLK_W-1:0] block_in_word, // ciphertext
   input wire logic decrypt_busy_flag, // decryption running
   input wire logic decrypt_done_flag, // last decryption cycle
   input wire logic plain_result_strobe, // result fresh
   input wire logic [BLK_W-1:0] plain_result_word // result word
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // timing of an accepted request
   a_key_busy_run: assert property (key_load_strobe && !key_setup_busy && !decrypt_busy_flag
      |=> key_setup_busy[*8]) else $error("key busy dropped early");
   a_key_done_at: assert property (key_load_strobe && !key_setup_busy && !decrypt_busy_flag
      |-> ##14 key_setup_done ##1 !key_setup_busy) else $error("key setup end misplaced");
   a_dec_busy_run: assert property (block_in_strobe && !key_load_strobe && !key_setup_busy
      && !decrypt_busy_flag |=> decrypt_busy_flag[*8]) else $error("decrypt busy dropped early");
   a_dec_done_at: assert property (block_in_strobe && !key_load_strobe && !key_setup_busy
      && !decrypt_busy_flag |-> ##14 decrypt_done_flag ##1 (plain_result_strobe && !decrypt_busy_flag))
      else $error("decrypt end misplaced");
   // refusal while busy
   a_key_refuse: assert property (key_setup_busy && !key_setup_done
      |=> key_setup_busy && !decrypt_busy_flag) else $error("request taken in key setup");
   a_dec_refuse: assert property (decrypt_busy_flag && !decrypt_done_flag
      |=> decrypt_busy_flag && !key_setup_busy) else $error("request taken in decryption");
   // pulses and held result
   a_done_single: assert property ((key_setup_done |=> !key_setup_done)
      and (decrypt_done_flag |=> !decrypt_done_flag)) else $error("done flag longer than one cycle");
   a_result_cause: assert property (plain_result_strobe |-> $past(decrypt_done_flag)
      ##1 !plain_result_strobe) else $error("result strobe without done");
   a_word_hold: assert property (!plain_result_strobe |-> $stable(plain_result_word))
      else $error("result word changed without strobe");
endmodule

bind aesd_decryptor aesd_decryptor_chk u_chk (.sys_clk(sys_clk), .nrst(nrst),
   .key_load_strobe(key_load_strobe), .key_word(key_word), .key_setup_busy(key_setup_busy),
   .key_setup_done(key_setup_done), .block_in_strobe(block_in_strobe), .block_in_word(block_in_word),
   .decrypt_busy_flag(decrypt_busy_flag), .decrypt_done_flag(decrypt_done_flag),
   .plain_result_strobe(plain_result_strobe), .plain_result_word(plain_result_word));

// ---- verification/aesd_user_model.sv ----
`timescale 1ns/100ps

module aesd_user_model
   import aesd_pkg::*;
(
   input wire logic sys_clk, // clock
   input wire logic decrypt_done_flag, // paces back-to-back blocks
   output logic key_load_strobe, // key request
   output logic [KEY_W-1:0] key_word, // key value
   output logic block_in_strobe, // block request
   output logic [BLK_W-1:0] block_in_word // ciphertext
);
   // quiet lines at time zero
   initial begin
      key_load_strobe = 1'b0;
      block_in_strobe = 1'b0;
      key_word = '0;
      block_in_word = '0;
   end

   // one request cycle; data valid only beside its strobe
   task automatic req(input logic ke, input logic [KEY_W-1:0] k, input logic be, input logic [BLK_W-1:0] b);
      @(negedge sys_clk);
      key_load_strobe <= ke;
      key_word <= k;
      block_in_strobe <= be;
      block_in_word <= b;
      @(negedge sys_clk);
      key_load_strobe <= 1'b0;
      block_in_strobe <= 1'b0;
      key_word <= ~k; // stale data scrambled
      block_in_word <= ~b;
   endtask

   // next block in the cycle after done is seen
   task automatic chain(input logic [BLK_W-1:0] b);
      @(negedge sys_clk);
      while (decrypt_done_flag !== 1'b1) @(negedge sys_clk);
      req(1'b0, ~key_word, 1'b1, b);
   endtask
endmodule

// ---- verification/tb_aes_block_decryptor.sv ----
`timescale 1ns/100ps

module tb_aes_block_decryptor;
   import aesd_pkg::*;
   localparam logic [KEY_W-1:0] VK = 256'h000102030405060708090A0B0C0D0E0F101112131415161718191A1B1C1D1E1F;
   localparam logic [BLK_W-1:0] VC = 128'h8EA2B7CA516745BFEAFC49904B496089;
   localparam logic [BLK_W-1:0] VP = 128'h00112233445566778899AABBCCDDEEFF;
   logic sys_clk, nrst, ks, kd, bs, db_f, dd, ps_o, kd_done;
   logic [KEY_W-1:0] kw, rk, mk;
   logic [BLK_W-1:0] bw, pw, rb;
   int kb, db, miscompares, tests_run, cyc;
   bit ps, ek;

   aesd_decryptor DUT (.sys_clk(sys_clk), .nrst(nrst), .key_load_strobe(ks), .key_word(kw),
      .key_setup_busy(kd), .key_setup_done(kd_done), .block_in_strobe(bs), .block_in_word(bw),
      .decrypt_busy_flag(db_f), .decrypt_done_flag(dd), .plain_result_strobe(ps_o), .plain_result_word(pw));
   aesd_user_model u_usr (.sys_clk(sys_clk), .decrypt_done_flag(dd), .key_load_strobe(ks), .key_word(kw),
      .block_in_strobe(bs), .block_in_word(bw));

   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;

   // reference: busy counters, stored key, expected result
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         kb = 0;
         db = 0;
         ps = 0;
         mk = '0;
      end else begin
         ps = (db == 1);
         if (kb > 0) kb--;
         else if (db > 0) db--;
         else if (ks) begin
            kb = 14;
            mk = kw;
         end else if (bs) begin
            db = 14;
            ek = (mk === VK) && (bw === VC);
         end
      end
   end

   task automatic chk(input bit c, input string m);
      tests_run++;
      if (!c) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   // compare every cycle where outputs are settled
   always @(negedge sys_clk) begin
      cyc++;
      if (cyc > 2000) begin
         miscompares++;
         results();
      end
      chk(kd === (kb != 0) && kd_done === (kb == 1), "key flags");
      chk(db_f === (db != 0) && dd === (db == 1) && ps_o === ps, "decrypt flags");
      if (ps && ek) chk(pw === VP, "plaintext");
   end

   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic settle;
      repeat (16) @(negedge sys_clk);
   endtask

   task automatic newr;
      for (int i = 0; i < 8; i++) rk[i*32 +: 32] = $urandom;
      rb = rk[255:128];
   endtask

   initial begin
      nrst = 1'b0;
      miscompares = 0;
      tests_run = 0;
      cyc = 0;
      rk = $urandom(42024);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      nrst <= 1'b1;
      // known vector, then requests thrown at both busy phases
      newr();
      u_usr.req(1'b1, VK, 1'b0, rb);
      u_usr.req(1'b1, rk, 1'b1, rb);
      settle();
      u_usr.req(1'b0, rk, 1'b1, VC);
      u_usr.req(1'b1, rk, 1'b1, rb);
      settle();
      $display("test 1 done");
      // back-to-back blocks at full rate
      u_usr.req(1'b0, rk, 1'b1, VC);
      repeat (3) u_usr.chain(VC);
      settle();
      $display("test 2 done");
      // key replaced, both strobes at once, key restored
      newr();
      u_usr.req(1'b1, rk, 1'b0, rb);
      settle();
      u_usr.req(1'b0, rk, 1'b1, rb);
      settle();
      u_usr.req(1'b1, VK, 1'b1, rb);
      settle();
      u_usr.req(1'b0, rk, 1'b1, VC);
      settle();
      $display("test 3 done");
      // reset in mid key setup
      u_usr.req(1'b1, rk, 1'b0, rb);
      repeat (4) @(negedge sys_clk);
      nrst <= 1'b0;
      @(negedge sys_clk);
      nrst <= 1'b1;
      u_usr.req(1'b1, VK, 1'b0, rb);
      settle();
      u_usr.req(1'b0, rk, 1'b1, VC);
      settle();
      $display("test 4 done");
      results();
   end
endmodule
